/* src/mcc_pkg.sv */
package mcc_pkg;

  // ----------------------------------------
  // Clock sources and sleep modes.
  // ----------------------------------------
  typedef enum logic [1:0] {MCC_SRC_FAST, MCC_SRC_LOWPWR, MCC_SRC_CRYSTAL, MCC_SRC_EXT} mcc_src_t;
  typedef enum logic [1:0] {MCC_ACTIVE, MCC_IDLE, MCC_STANDBY, MCC_POWERDOWN} mcc_sleep_t;

  localparam int MCC_NSRC = 4;
  localparam int MCC_DIVW = 7;
  localparam int MCC_FSELW = 2;

  // ----------------------------------------
  // Reset values and field layout.
  // ----------------------------------------
  localparam mcc_src_t MCC_SEL_RESET = MCC_SRC_FAST;
  localparam logic MCC_PEN_RESET = 1'h1;
  localparam logic [3:0] MCC_PDIV_RESET = 4'h8;
  localparam int MCC_OSC_CRYSTAL_EN = 0;
  localparam int MCC_OSC_RS_LSB = 1;

  // ----------------------------------------
  // Timing counts.
  // ----------------------------------------
  localparam logic [2:0] MCC_CCP_WINDOW = 3'h4;
  localparam logic [1:0] MCC_EXT_READY_EDGES = 2'h2;
  localparam int MCC_STABLE_EDGES = 8;

  // Prescaler code to division factor; twelve settings from 1 to 64.
  function automatic logic [MCC_DIVW-1:0] mcc_div(input logic pen, input logic [3:0] pdiv);
    logic [MCC_DIVW-1:0] d;
    d = 7'h01;
    if (pen) begin
      unique case (pdiv)
        4'h0: d = 7'h02;
        4'h1: d = 7'h04;
        4'h2: d = 7'h08;
        4'h3: d = 7'h10;
        4'h4: d = 7'h20;
        4'h5: d = 7'h40;
        4'h8: d = 7'h06;
        4'h9: d = 7'h0A;
        4'hA: d = 7'h0C;
        4'hB: d = 7'h18;
        4'hC: d = 7'h30;
        default: d = 7'h02;
      endcase
    end
    return d;
  endfunction

endpackage

/* src/mcc_clk_if.sv */
`timescale 1ns/1ns
interface mcc_clk_if;
  import mcc_pkg::*;

  logic                     req_valid;
  mcc_src_t                 req_src;
  mcc_src_t                 cur_src;
  mcc_src_t                 tgt_src;
  logic                     gate;
  logic                     switching;
  logic [MCC_NSRC-1:0]      src_ready;
  logic [MCC_NSRC-1:0]      src_edge;
  logic                     pen;
  logic [3:0]               pdiv;
  logic                     run;
  logic                     tick;

  modport top (output req_valid, req_src, src_ready, src_edge, pen, pdiv, run,
               input cur_src, tgt_src, gate, switching, tick);
  modport sw (input req_valid, req_src, src_ready, src_edge,
              output cur_src, tgt_src, gate, switching);
  modport ps (input pen, pdiv, run, output tick);
endinterface

/* src/mcc_switch.sv */
`timescale 1ns/1ns
module mcc_switch
  import mcc_pkg::*;
#(
  parameter int STABLE_EDGES = MCC_STABLE_EDGES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Source change channel.
  mcc_clk_if.sw    sw
);

  typedef enum logic [1:0] {MCC_SW_IDLE, MCC_SW_WAIT, MCC_SW_GATE} mcc_sw_state_t;

  mcc_sw_state_t  state;
  mcc_sw_state_t  next_state;
  mcc_src_t       cur;
  mcc_src_t       next_cur;
  mcc_src_t       tgt;
  mcc_src_t       next_tgt;
  logic [7:0]     cnt;
  logic [7:0]     next_cnt;
  logic           ext_tgt;

  assign ext_tgt = (tgt == MCC_SRC_CRYSTAL) || (tgt == MCC_SRC_EXT);

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_tgt = tgt;
    next_cnt = cnt;
    unique case (state)
      MCC_SW_IDLE: begin
        if (sw.req_valid && sw.req_src != cur) begin // [R09]
          next_tgt = sw.req_src;
          next_cnt = 8'h00;
          next_state = MCC_SW_WAIT;
        end
      end
      MCC_SW_WAIT: begin
        if (ext_tgt) begin
          if (sw.src_edge[tgt]) begin // [R08]
            next_cnt = cnt + 8'h01;
            if (cnt == 8'(STABLE_EDGES - 1)) begin
              next_state = MCC_SW_GATE;
            end
          end
        end else if (sw.src_ready[tgt]) begin
          next_state = MCC_SW_GATE;
        end
      end
      MCC_SW_GATE: begin
        next_cur = tgt; // [R26]
        next_state = MCC_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= MCC_SW_IDLE;
      cur <= MCC_SEL_RESET;
      tgt <= MCC_SEL_RESET;
      cnt <= 8'h00;
    end else begin
      state <= next_state;
      cur <= next_cur;
      tgt <= next_tgt;
      cnt <= next_cnt;
    end
  end

  assign sw.cur_src = cur;
  assign sw.tgt_src = tgt;
  assign sw.gate = (state != MCC_SW_GATE); // [R26]
  assign sw.switching = (state != MCC_SW_IDLE); // [R10]

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_accept;
    state == MCC_SW_IDLE && sw.req_valid && sw.req_src != cur;
  endsequence

  property p_flag_on_accept;
    s_accept |=> sw.switching;
  endproperty
  a_flag_on_accept: assert property (p_flag_on_accept) else $error("switch flag not set"); // [R10]

  property p_refuse_busy;
    sw.switching && state == MCC_SW_WAIT |=> tgt == $past(tgt);
  endproperty
  a_refuse_busy: assert property (p_refuse_busy) else $error("target changed mid switch"); // [R09]

  property p_glitchless;
    cur != $past(cur) |-> $past(!sw.gate) && sw.gate;
  endproperty
  a_glitchless: assert property (p_glitchless) else $error("source changed with gate open"); // [R26]

  property p_ext_edges;
    state == MCC_SW_WAIT && ext_tgt && cnt < 8'(STABLE_EDGES - 1) |=> state != MCC_SW_GATE;
  endproperty
  a_ext_edges: assert property (p_ext_edges) else $error("switch before enough edges"); // [R08]

endmodule

/* src/mcc_prescale.sv */
`timescale 1ns/1ns
module mcc_prescale
  import mcc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Prescaler channel.
  mcc_clk_if.ps    ps
);

  logic [MCC_DIVW-1:0] div;
  logic [MCC_DIVW-1:0] cnt;
  logic [MCC_DIVW-1:0] next_cnt;
  logic                tick;
  logic                next_tick;

  assign div = mcc_div(ps.pen, ps.pdiv);

  always_comb begin
    next_tick = ps.run && (cnt >= div - 7'h01); // [R13]
    next_cnt = (next_tick || !ps.run) ? 7'h00 : cnt + 7'h01;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 7'h00;
      tick <= 1'h0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  assign ps.tick = tick;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_div_one;
    ps.run && div == 7'h01 |=> tick;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one missed a tick"); // [R13]

endmodule

/* src/mcc_main.sv */
`timescale 1ns/1ns
// How it works
// (R01) An internal oscillator starts by itself once any peripheral requests it.
// (R02) An oscillator nobody uses or requests stops unless run-in-standby holds it.
// (R03) Run-in-standby keeps an oscillator running in every mode except power-down.
// (R04) With run-in-standby set, requests find the oscillator already running.
// (R05) The main clock always runs in active and idle modes.
// (R06) In standby the main clock runs only when requested or held by run-in-standby.
// (R07) Power-down stops the main clock only after memory operations finish.
// (R08) A switch to an external source completes only after enough edges are seen.
// (R09) While such a switch waits, every further source change is refused.
// (R10) A switching flag stands while a source change is in progress.
// (R11) Separate stable flags report the external input and the crystal.
// (R12) One status bit per oscillator shows it is running and stable.
// (R13) The peripheral clock is the main clock divided by one of twelve factors.
// (R14) After reset the main clock is the fast oscillator divided by six.
// (R15) The fast oscillator frequency is taken from the fuse after reset.
// (R16) The crystal is never a source until its enable bit is written one.
// (R17) The main source comes from the select field; async clocks choose their own.
// (R18) The CPU clock feeds CPU, SRAM and memory controller; others get the prescaled one.
// (R19) Counter clock requested when counter or timer enabled; watchdog clock when enabled.
// (R20) Brown-out clock requested only in sampled mode of the detector.
// (R21) A request goes to the source the peripheral is configured for.
// (R22) Main select and prescaler writes are taken only via the protected procedure.
// (R23) Software changes the counter clock source only while the counter is off.
// (R24) A protected write counts only within four instructions after the key.
// (R25) The external clock input is ready two of its cycles after first request.
// (R26) The switch flag spans the write to the handover; handover is glitch-free, with the gate closed for one cycle.
module mcc_main
  import mcc_pkg::*;
#(
  parameter int STABLE_EDGES = MCC_STABLE_EDGES
) (
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  // Fuse and sleep state.
  input  wire logic [MCC_FSELW-1:0] frequency_select,
  input  wire mcc_sleep_t           sleep_mode,
  input  wire logic                 nvm_busy,
  // Change protection.
  input  wire logic                 change_protection_key,
  input  wire logic                 instr_retire,
  // Protected writes.
  input  wire logic                 main_select_write,
  input  wire mcc_src_t             main_source_select,
  input  wire logic                 prescaler_write,
  input  wire logic                 prescaler_enable,
  input  wire logic [3:0]           prescaler_div,
  input  wire logic                 osc_control_write,
  input  wire logic [3:0]           osc_control_data,
  // Peripheral requests.
  input  wire logic [MCC_NSRC-1:0]  periph_request,
  input  wire logic                 main_request,
  input  wire logic                 realtime_counter_enable,
  input  wire logic                 realtime_timer_enable,
  input  wire mcc_src_t             realtime_counter_source,
  input  wire logic                 watchdog_enable,
  input  wire logic                 brownout_detector_enable,
  input  wire logic                 brownout_sampled_mode,
  // Oscillator side.
  input  wire logic [MCC_NSRC-1:0]  osc_ready,
  input  wire logic [MCC_NSRC-1:0]  osc_edge,
  output logic [MCC_NSRC-1:0]       osc_enable,
  output logic [MCC_FSELW-1:0]      fast_osc_frequency,
  // Clock outputs.
  output mcc_src_t                  main_source,
  output logic                      cpu_clock_run,
  output logic                      peripheral_clock,
  output logic                      watchdog_clock,
  output logic                      brownout_clock,
  output logic                      realtime_counter_clock,
  // Status.
  output logic                      source_switching,
  output logic                      ext_input_stable,
  output logic                      crystal_stable,
  output logic [MCC_NSRC-1:0]       osc_stable,
  output logic                      crystal_enable,
  output logic [MCC_NSRC-1:0]       run_in_standby
);

  // ----------------------------------------
  // Change protection window.
  // ----------------------------------------
  logic [2:0] ccp_left;
  logic [2:0] next_ccp_left;
  logic       unlocked;

  assign unlocked = (ccp_left != 3'h0); // [R24]

  always_comb begin
    next_ccp_left = ccp_left;
    if (change_protection_key) begin
      next_ccp_left = MCC_CCP_WINDOW; // [R24]
    end else if (instr_retire && unlocked) begin
      next_ccp_left = ccp_left - 3'h1;
    end
  end

  // ----------------------------------------
  // Protected control bits and fuse frequency.
  // ----------------------------------------
  logic                 pen;
  logic                 next_pen;
  logic [3:0]           pdiv;
  logic [3:0]           next_pdiv;
  logic                 xtal_en;
  logic                 next_xtal_en;
  logic [MCC_NSRC-1:0]  rs;
  logic [MCC_NSRC-1:0]  next_rs;
  logic [MCC_FSELW-1:0] fsel;
  logic [MCC_FSELW-1:0] next_fsel;
  logic                 fuse_taken;
  logic                 next_fuse_taken;

  always_comb begin
    next_pen = pen;
    next_pdiv = pdiv;
    next_xtal_en = xtal_en;
    next_rs = rs;
    next_fsel = fsel;
    next_fuse_taken = 1'h1;
    if (!fuse_taken) begin
      next_fsel = frequency_select; // [R15]
    end
    if (prescaler_write && unlocked) begin // [R22]
      next_pen = prescaler_enable;
      next_pdiv = prescaler_div;
    end
    if (osc_control_write && unlocked) begin // [R22]
      next_xtal_en = osc_control_data[MCC_OSC_CRYSTAL_EN]; // [R16]
      next_rs = {1'h0, osc_control_data[MCC_OSC_RS_LSB +: 3]};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ccp_left <= 3'h0;
      pen <= MCC_PEN_RESET; // [R14]
      pdiv <= MCC_PDIV_RESET; // [R14]
      xtal_en <= 1'h0;
      rs <= '0;
      fsel <= '0;
      fuse_taken <= 1'h0;
    end else begin
      ccp_left <= next_ccp_left;
      pen <= next_pen;
      pdiv <= next_pdiv;
      xtal_en <= next_xtal_en;
      rs <= next_rs;
      fsel <= next_fsel;
      fuse_taken <= next_fuse_taken;
    end
  end

  // ----------------------------------------
  // Switcher and prescaler.
  // ----------------------------------------
  mcc_clk_if cif ();

  mcc_switch #(
    .STABLE_EDGES (STABLE_EDGES)
  ) u_switch (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sw       (cif.sw)
  );

  mcc_prescale u_prescale (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ps       (cif.ps)
  );

  // ----------------------------------------
  // Requests, oscillator enables and readiness.
  // ----------------------------------------
  logic [MCC_NSRC-1:0] demand;
  logic [MCC_NSRC-1:0] next_enable;
  logic [MCC_NSRC-1:0] ready;
  logic                main_run;
  logic                rtc_req;
  logic [1:0]          ext_cnt;
  logic [1:0]          next_ext_cnt;

  assign rtc_req = realtime_counter_enable || realtime_timer_enable; // [R19]

  always_comb begin
    unique case (sleep_mode)
      MCC_ACTIVE, MCC_IDLE: main_run = 1'h1; // [R05]
      MCC_STANDBY: main_run = main_request || rs[cif.cur_src]; // [R06]
      MCC_POWERDOWN: main_run = nvm_busy; // [R07]
    endcase
  end

  generate
    for (genvar i = 0; i < MCC_NSRC; i++) begin : g_osc
      assign demand[i] = periph_request[i]
                      || (rtc_req && realtime_counter_source == mcc_src_t'(i)); // [R21]
      always_comb begin
        next_enable[i] = demand[i] // [R01]
                      || (main_run && cif.cur_src == mcc_src_t'(i))
                      || (cif.switching && cif.tgt_src == mcc_src_t'(i))
                      || (rs[i] && sleep_mode != MCC_POWERDOWN); // [R02] [R03] [R04]
        if (i == int'(MCC_SRC_CRYSTAL) && !xtal_en) begin
          next_enable[i] = 1'h0; // [R16]
        end
      end
      if (i == int'(MCC_SRC_EXT)) begin : g_ext
        assign ready[i] = osc_enable[i] && (ext_cnt == MCC_EXT_READY_EDGES); // [R25]
      end else begin : g_int
        assign ready[i] = osc_enable[i] && osc_ready[i]; // [R12]
      end
    end
  endgenerate

  always_comb begin
    next_ext_cnt = ext_cnt;
    if (!osc_enable[MCC_SRC_EXT]) begin
      next_ext_cnt = 2'h0;
    end else if (osc_edge[MCC_SRC_EXT] && ext_cnt != MCC_EXT_READY_EDGES) begin
      next_ext_cnt = ext_cnt + 2'h1; // [R25]
    end
  end

  assign cif.req_valid = main_select_write && unlocked; // [R22] [R17]
  assign cif.req_src = main_source_select;
  assign cif.src_ready = ready;
  assign cif.src_edge = osc_edge & osc_enable;
  assign cif.pen = pen;
  assign cif.pdiv = pdiv;
  assign cif.run = main_run && cif.gate;

  // ----------------------------------------
  // Output registers.
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_enable <= '0;
      ext_cnt <= 2'h0;
      osc_stable <= '0;
      cpu_clock_run <= 1'h0;
      watchdog_clock <= 1'h0;
      brownout_clock <= 1'h0;
      realtime_counter_clock <= 1'h0;
    end else begin
      osc_enable <= next_enable;
      ext_cnt <= next_ext_cnt;
      osc_stable <= ready; // [R12]
      cpu_clock_run <= main_run && cif.gate; // [R18]
      watchdog_clock <= watchdog_enable; // [R19]
      brownout_clock <= brownout_detector_enable && brownout_sampled_mode; // [R20]
      realtime_counter_clock <= rtc_req; // [R19]
    end
  end

  assign peripheral_clock = cif.tick; // [R18] [R13]
  assign main_source = cif.cur_src;
  assign source_switching = cif.switching; // [R10]
  assign ext_input_stable = osc_stable[MCC_SRC_EXT]; // [R11]
  assign crystal_stable = osc_stable[MCC_SRC_CRYSTAL]; // [R11]
  assign fast_osc_frequency = fsel;
  assign crystal_enable = xtal_en;
  assign run_in_standby = rs;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_protect;
    prescaler_write && !unlocked && !change_protection_key |=> $stable(pdiv) && $stable(pen);
  endproperty
  a_protect: assert property (p_protect) else $error("unprotected prescaler write taken"); // [R22]

  property p_window;
    change_protection_key ##1 (instr_retire && !change_protection_key) [*4] |=> !unlocked;
  endproperty
  a_window: assert property (p_window) else $error("window open past four instructions"); // [R24]

  property p_xtal_off;
    !xtal_en |=> !osc_enable[MCC_SRC_CRYSTAL];
  endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("crystal enabled without enable bit"); // [R16]

  property p_pwrdn;
    sleep_mode == MCC_POWERDOWN && nvm_busy && cif.gate |=> cpu_clock_run;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("main clock stopped during memory busy"); // [R07]

  property p_active;
    sleep_mode inside {MCC_ACTIVE, MCC_IDLE} && cif.gate |=> cpu_clock_run;
  endproperty
  a_active: assert property (p_active) else $error("main clock stopped in active or idle"); // [R05]

  property p_standby_hold;
    rs[MCC_SRC_FAST] && sleep_mode != MCC_POWERDOWN |=> osc_enable[MCC_SRC_FAST];
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("run in standby not honoured"); // [R03]

  property p_request;
    periph_request[MCC_SRC_LOWPWR] |=> osc_enable[MCC_SRC_LOWPWR];
  endproperty
  a_request: assert property (p_request) else $error("requested oscillator not started"); // [R01]

  property p_bod;
    brownout_detector_enable && !brownout_sampled_mode |=> !brownout_clock;
  endproperty
  a_bod: assert property (p_bod) else $error("brown-out clock outside sampled mode"); // [R20]

endmodule

/* verification/mcc_osc_model.sv */
`timescale 1ns/1ns
module mcc_osc_model
  import mcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // Oscillator control.
  input  wire logic [MCC_NSRC-1:0] osc_enable,
  input  wire logic                edges_on,
  // Oscillator outputs.
  output logic [MCC_NSRC-1:0]      osc_ready,
  output logic [MCC_NSRC-1:0]      osc_edge
);
  logic [1:0] age [MCC_NSRC];
  logic       ph;
  // A source with edges on is ready three cycles after enable; it edges every other cycle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ph <= 1'h0;
      for (int i = 0; i < MCC_NSRC; i++) age[i] <= 2'h0;
    end else begin
      ph <= ~ph;
      for (int i = 0; i < MCC_NSRC; i++) age[i] <= !osc_enable[i] ? 2'h0 :
                                                   age[i] + {1'h0, edges_on && age[i] != 2'h3};
    end
  end
  always_comb begin
    for (int i = 0; i < MCC_NSRC; i++) begin
      osc_ready[i] = age[i] == 2'h3;
      osc_edge[i]  = osc_enable[i] && edges_on && ph;
    end
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import mcc_pkg::*;
  typedef struct {string n; int i; logic [7:0] v;} mcc_note_t;
  logic core_clk, resetn, nvm_busy, change_protection_key, instr_retire, main_select_write;
  logic prescaler_write, prescaler_enable, osc_control_write, main_request, edges_on;
  logic realtime_counter_enable, realtime_timer_enable, watchdog_enable;
  logic brownout_detector_enable, brownout_sampled_mode, peripheral_clock, cpu_clock_run;
  logic watchdog_clock, brownout_clock, realtime_counter_clock, source_switching;
  logic ext_input_stable, crystal_stable, crystal_enable;
  logic [MCC_FSELW-1:0] frequency_select, fast_osc_frequency;
  logic [3:0] prescaler_div, osc_control_data;
  logic [MCC_NSRC-1:0] periph_request, osc_ready, osc_edge, osc_enable, osc_stable;
  logic [MCC_NSRC-1:0] run_in_standby;
  mcc_sleep_t sleep_mode;
  mcc_src_t main_source_select, realtime_counter_source, main_source;
  mcc_note_t q[$];
  mcc_note_t e;
  event chk;
  int miscompares, cmp_count, meas, off;
  logic [31:0] seed = 32'h9FFB;
  logic [4:0] pcode [12] = '{5'h00, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18,
                             5'h19, 5'h1A, 5'h1B, 5'h1C};
  logic [7:0] pdivs [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h06,
                             8'h0A, 8'h0C, 8'h18, 8'h30};

  mcc_main #(.STABLE_EDGES(4)) dut (.core_clk, .resetn, .frequency_select, .sleep_mode,
    .nvm_busy, .change_protection_key, .instr_retire, .main_select_write,
    .main_source_select, .prescaler_write, .prescaler_enable, .prescaler_div,
    .osc_control_write, .osc_control_data, .periph_request, .main_request,
    .realtime_counter_enable, .realtime_timer_enable, .realtime_counter_source,
    .watchdog_enable, .brownout_detector_enable, .brownout_sampled_mode, .osc_ready,
    .osc_edge, .osc_enable, .fast_osc_frequency, .main_source, .cpu_clock_run,
    .peripheral_clock, .watchdog_clock, .brownout_clock, .realtime_counter_clock,
    .source_switching, .ext_input_stable, .crystal_stable, .osc_stable, .crystal_enable,
    .run_in_standby);
  mcc_osc_model osc (.core_clk, .resetn, .osc_enable, .edges_on, .osc_ready, .osc_edge);

  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] obs(string n, int i);
    case (n)
      "src": return {6'h0, main_source};
      "sw": return {7'h0, source_switching};
      "run": return {7'h0, cpu_clock_run};
      "en": return {7'h0, osc_enable[i]};
      "st": return {7'h0, osc_stable[i]};
      "rs": return {7'h0, run_in_standby[i]};
      "xs": return {7'h0, ext_input_stable};
      "cs": return {7'h0, crystal_stable};
      "ce": return {7'h0, crystal_enable};
      "wd": return {7'h0, watchdog_clock};
      "bo": return {7'h0, brownout_clock};
      "rc": return {7'h0, realtime_counter_clock};
      "fq": return {6'h0, fast_osc_frequency};
      default: return meas[7:0];
    endcase
  endfunction
  task automatic note_exp(string n, int i, logic [7:0] v);
    q.push_back('{n, i, v});
    ->chk;
  endtask
  task automatic chk_at(string n, int i, logic [7:0] v, int lim);
    for (int c = 0; c < lim && obs(n, i) !== v; c++) @(negedge core_clk);
    note_exp(n, i, v);
  endtask
  task automatic period(logic [7:0] v);
    repeat (2) begin
      for (int c = 0; c < 200 && peripheral_clock !== 1'h1; c++) @(negedge core_clk);
      @(negedge core_clk);
      meas = 1;
      for (int c = 0; c < 200 && peripheral_clock !== 1'h1; c++) begin
        @(negedge core_clk);
        meas++;
      end
    end
    note_exp("div", 0, v);
  endtask
  task automatic pw(int k, logic [4:0] d, int gap);
    @(negedge core_clk);
    change_protection_key = 1'h1;
    @(negedge core_clk);
    change_protection_key = 1'h0;
    instr_retire = 1'h1;
    repeat (gap) @(negedge core_clk);
    {main_select_write, prescaler_write, osc_control_write} = {k == 0, k == 1, k == 2};
    main_source_select = mcc_src_t'(d[1:0]);
    {prescaler_enable, prescaler_div} = d;
    osc_control_data = d[3:0];
    @(negedge core_clk);
    {main_select_write, prescaler_write, osc_control_write, instr_retire} = 4'h0;
  endtask
  task automatic rst();
    resetn = 1'h0;
    seed = xs(seed);
    frequency_select = seed[1:0];
    repeat (2) @(negedge core_clk);
    resetn = 1'h1;
    chk_at("src", 0, MCC_SRC_FAST, 1);
    chk_at("fq", 0, {6'h0, frequency_select}, 3);
    note_exp("sw", 0, 8'h00);
    period(8'h06);
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, checker and watchdog.
  // ----------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    forever begin
      @chk;
      while (q.size() > 0) begin
        e = q.pop_front();
        cmp_count++;
        if (obs(e.n, e.i) !== e.v) begin
          miscompares++;
          $display("CHECK FAILED %s[%0d] expected %h seen %h", e.n, e.i, e.v, obs(e.n, e.i));
        end
      end
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    results();
  end

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    {nvm_busy, change_protection_key, instr_retire, main_select_write, main_request} = 5'h0;
    {prescaler_write, prescaler_enable, osc_control_write, watchdog_enable} = 4'h0;
    {realtime_counter_enable, realtime_timer_enable, brownout_detector_enable} = 3'h0;
    {brownout_sampled_mode, prescaler_div, osc_control_data, periph_request} = 13'h0;
    main_source_select = MCC_SRC_FAST;
    realtime_counter_source = MCC_SRC_FAST;
    sleep_mode = MCC_ACTIVE;
    edges_on = 1'h1;
    frequency_select = 2'h0;
    rst();
    pw(1, 5'h10, 4);
    period(8'h06);
    off = seed % 12;
    for (int k = 0; k < 12; k++) begin
      pw(1, pcode[(k + off) % 12], 0);
      period(pdivs[(k + off) % 12]);
    end
    periph_request = 4'h2;
    chk_at("en", 1, 8'h01, 8);
    periph_request = 4'h0;
    chk_at("en", 1, 8'h00, 8);
    realtime_counter_source = MCC_SRC_LOWPWR;
    realtime_timer_enable = 1'h1;
    chk_at("rc", 0, 8'h01, 4);
    chk_at("en", 1, 8'h01, 8);
    {watchdog_enable, brownout_detector_enable, brownout_sampled_mode} = 3'h7;
    chk_at("wd", 0, 8'h01, 4);
    chk_at("bo", 0, 8'h01, 4);
    brownout_sampled_mode = 1'h0;
    chk_at("bo", 0, 8'h00, 4);
    {watchdog_enable, brownout_detector_enable, realtime_timer_enable} = 3'h0;
    chk_at("en", 1, 8'h00, 8);
    pw(2, 5'h04, 0);
    chk_at("rs", 1, 8'h01, 3);
    chk_at("st", 1, 8'h01, 8);
    periph_request = 4'h2;
    @(negedge core_clk);
    note_exp("st", 1, 8'h01);
    note_exp("en", 1, 8'h01);
    periph_request = 4'h0;
    nvm_busy = 1'h1;
    sleep_mode = MCC_POWERDOWN;
    repeat (6) @(negedge core_clk);
    note_exp("run", 0, 8'h01);
    nvm_busy = 1'h0;
    chk_at("run", 0, 8'h00, 8);
    chk_at("en", 1, 8'h00, 8);
    sleep_mode = MCC_IDLE;
    chk_at("run", 0, 8'h01, 8);
    sleep_mode = MCC_STANDBY;
    chk_at("run", 0, 8'h00, 8);
    main_request = 1'h1;
    chk_at("run", 0, 8'h01, 8);
    main_request = 1'h0;
    chk_at("run", 0, 8'h00, 8);
    pw(2, 5'h02, 0);
    chk_at("run", 0, 8'h01, 8);
    sleep_mode = MCC_ACTIVE;
    periph_request = 4'h4;
    repeat (8) @(negedge core_clk);
    note_exp("en", 2, 8'h00);
    pw(2, 5'h01, 0);
    chk_at("ce", 0, 8'h01, 3);
    chk_at("en", 2, 8'h01, 8);
    periph_request = 4'h0;
    pw(0, 5'h03, 0);
    chk_at("sw", 0, 8'h01, 3);
    note_exp("src", 0, MCC_SRC_FAST);
    chk_at("src", 0, MCC_SRC_EXT, 60);
    note_exp("sw", 0, 8'h00);
    note_exp("xs", 0, 8'h01);
    edges_on = 1'h0;
    pw(0, 5'h02, 0);
    chk_at("sw", 0, 8'h01, 3);
    pw(0, 5'h00, 0);
    repeat (20) @(negedge core_clk);
    note_exp("src", 0, MCC_SRC_EXT);
    note_exp("sw", 0, 8'h01);
    note_exp("cs", 0, 8'h00);
    rst();
    edges_on = 1'h1;
    pw(2, 5'h01, 0);
    pw(0, 5'h02, 0);
    chk_at("src", 0, MCC_SRC_CRYSTAL, 60);
    note_exp("cs", 0, 8'h01);
    pw(0, 5'h01, 0);
    chk_at("src", 0, MCC_SRC_LOWPWR, 30);
    pw(0, 5'h00, 0);
    chk_at("src", 0, MCC_SRC_FAST, 30);
    @(negedge core_clk);
    results();
  end
endmodule
